// File: src/lcp_target.sv
/*
 * Serial-bus target front end of the LED driver: address decode, control
 * register, pointer stepping and the register access port.
 * Assumes osc_clk_i is the internal oscillator, several times faster than
 * the bus clock; the register port on clk_i answers reads in the cycle of
 * reg_rd_o. The bus engine lives on osc_clk_i, the port on clk_i.
 */
`timescale 1ns/10ps
`include "lcp_defines.svh"

module lcp_target
    import lcp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_clk_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [6:0] target_addr_i,
    input wire logic group_call_en_i,
    input wire logic [2:0] sub_call_en_i,
    output logic [4:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    output logic soft_reset_call_o
);
    // ************************************************************
    // link domain: pin conditioning
    // ************************************************************
    logic scl_f;
    logic sda_f;
    logic [6:0] strap_f;
    logic [3:0] en_f;
    logic rd_ack_f;
    logic scl_q_r;
    logic sda_q_r;

    lcp_sync #(.W(2), .RST(2'b11)) u_pin_sync
    (
        .clk_i(osc_clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i}),
        .q_o({scl_f, sda_f})
    );

    lcp_sync #(.W(7), .RST(7'h00)) u_strap_sync
    (
        .clk_i(osc_clk_i),
        .rst_i(rst_i),
        .d_i(target_addr_i),
        .q_o(strap_f)
    );

    // group call comes out of reset enabled, sub-calls disabled
    lcp_sync #(.W(4), .RST(4'h8)) u_en_sync
    (
        .clk_i(osc_clk_i),
        .rst_i(rst_i),
        .d_i({group_call_en_i, sub_call_en_i}),
        .q_o(en_f)
    );

    always_ff @(posedge osc_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_f;
            sda_q_r <= sda_f;
        end
    end

    logic bus_start;
    logic bus_stop;
    logic scl_rise;
    logic scl_fall;

    assign bus_start = scl_f & scl_q_r & sda_q_r & ~sda_f;
    assign bus_stop = scl_f & scl_q_r & ~sda_q_r & sda_f;
    assign scl_rise = scl_f & ~scl_q_r;
    assign scl_fall = ~scl_f & scl_q_r;

    // ************************************************************
    // link domain: address match and control register
    // ************************************************************
    lcp_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] ctrl_r;
    logic first_r;
    logic soft_r;
    logic rd_r;
    logic mack_r;
    logic rd_seen_r;
    logic [7:0] group_call_address_reg;
    logic [7:0] sub_call_address_reg_1;
    logic [7:0] sub_call_address_reg_2;
    logic [7:0] sub_call_address_reg_3;
    logic [7:0] rd_data_x_r;
    lcp_ptr_t ptr;
    logic ptr_ok;
    logic hit_call;
    logic hit_soft;
    logic byte_in;
    logic ack_w;
    logic do_ctrl;
    logic do_data;
    logic rd_done;
    logic enter_rload;
    logic [7:0] rd_byte;

    lcp_step_if step ();

    assign step.ctrl = ctrl_r;

    lcp_ptr_step u_step
    (
        .step(step)
    );

    assign ptr = ctrl_r[`LCP_CTRL_PTR_MSB:0];
    assign ptr_ok = ptr <= `LCP_PTR_LAST;

    // strap compared with no reserved-value exclusion
    assign hit_call = (sh_r[7:1] == strap_f)
        | (en_f[3] & (sh_r[7:1] == group_call_address_reg[7:1]))
        | (en_f[2] & (sh_r[7:1] == sub_call_address_reg_1[7:1]))
        | (en_f[1] & (sh_r[7:1] == sub_call_address_reg_2[7:1]))
        | (en_f[0] & (sh_r[7:1] == sub_call_address_reg_3[7:1]));
    // full byte compare: the read form of the call never matches
    assign hit_soft = sh_r == `LCP_SOFT_RESET_CALL;

    assign byte_in = scl_fall & (cnt_r == `LCP_BITS_PER_BYTE);
    assign ack_w = soft_r
        | (first_r ? (sh_r[`LCP_CTRL_PTR_MSB:0] <= `LCP_PTR_LAST) : ptr_ok);
    assign do_ctrl = (state_r == ST_WBYTE) & byte_in & first_r & ~soft_r & ack_w;
    assign do_data = (state_r == ST_WBYTE) & byte_in & ~first_r & ~soft_r & ptr_ok;
    assign rd_done = (state_r == ST_RBYTE) & scl_fall & (cnt_r == `LCP_LAST_BIT);
    assign enter_rload = scl_fall & (((state_r == ST_ADDR_ACK) & rd_r)
        | ((state_r == ST_RACK) & mack_r));

    always_comb
    begin
        unique case (ptr)
            `LCP_PTR_SUB1: rd_byte = sub_call_address_reg_1;
            `LCP_PTR_SUB2: rd_byte = sub_call_address_reg_2;
            `LCP_PTR_SUB3: rd_byte = sub_call_address_reg_3;
            `LCP_PTR_GRP_ADDR: rd_byte = group_call_address_reg;
            default: rd_byte = ptr_ok ? rd_data_x_r : 8'h00;
        endcase
    end

    // the control byte loads all bits; after it only the pointer field moves and the option bits hold
    always_ff @(posedge osc_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctrl_r <= `LCP_CTRL_RST;
        else if (do_ctrl)
            ctrl_r <= sh_r;
        else if (do_data || rd_done)
            ctrl_r[`LCP_CTRL_PTR_MSB:0] <= step.ptr_nxt;
    end

    // address registers are volatile: reset restores the defaults
    always_ff @(posedge osc_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            group_call_address_reg <= `LCP_GRP_ADDR_RST;
            sub_call_address_reg_1 <= `LCP_SUB1_ADDR_RST;
            sub_call_address_reg_2 <= `LCP_SUB2_ADDR_RST;
            sub_call_address_reg_3 <= `LCP_SUB3_ADDR_RST;
        end
        else if (do_data)
        begin
            if (ptr == `LCP_PTR_GRP_ADDR)
                group_call_address_reg <= sh_r;
            if (ptr == `LCP_PTR_SUB1)
                sub_call_address_reg_1 <= sh_r;
            if (ptr == `LCP_PTR_SUB2)
                sub_call_address_reg_2 <= sh_r;
            if (ptr == `LCP_PTR_SUB3)
                sub_call_address_reg_3 <= sh_r;
        end
    end

    // ************************************************************
    // link domain: bus engine
    // ************************************************************
    always_ff @(posedge osc_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            first_r <= 1'b0;
            soft_r <= 1'b0;
            rd_r <= 1'b0;
            mack_r <= 1'b0;
            rd_seen_r <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end
        else if (bus_start)
        begin
            state_r <= ST_ADDR;
            cnt_r <= 4'h0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_r <= ST_IDLE;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    sda_oe_o <= 1'b0;
                end
                ST_ADDR, ST_WBYTE:
                begin
                    if (scl_rise && cnt_r != `LCP_BITS_PER_BYTE)
                    begin
                        sh_r <= {sh_r[6:0], sda_f};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    else if (byte_in && state_r == ST_ADDR)
                    begin
                        if (hit_call || hit_soft)
                        begin
                            sda_oe_o <= 1'b1;
                            state_r <= ST_ADDR_ACK;
                            rd_r <= sh_r[0];
                            soft_r <= ~hit_call;
                            first_r <= 1'b1;
                        end
                        else
                            state_r <= ST_IDLE;
                    end
                    else if (byte_in)
                    begin
                        sda_oe_o <= ack_w;
                        first_r <= 1'b0;
                        state_r <= ST_WACK;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_o <= 1'b0;
                        cnt_r <= 4'h0;
                        // stretch the clock until the read byte is fetched
                        scl_oe_o <= rd_r;
                        state_r <= rd_r ? ST_RLOAD : ST_WBYTE;
                    end
                end
                ST_WACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_o <= 1'b0;
                        cnt_r <= 4'h0;
                        state_r <= ST_WBYTE;
                    end
                end
                ST_RLOAD:
                begin
                    if (rd_ack_f != rd_seen_r)
                    begin
                        rd_seen_r <= rd_ack_f;
                        sh_r <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                        cnt_r <= 4'h0;
                        state_r <= ST_RBYTE;
                    end
                end
                ST_RBYTE:
                begin
                    if (rd_done)
                    begin
                        sda_oe_o <= 1'b0;
                        state_r <= ST_RACK;
                    end
                    else if (scl_fall)
                    begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        sda_oe_o <= ~sh_r[6];
                        cnt_r <= cnt_r + 4'h1;
                    end
                    // bit 7 gets a cycle of setup before the clock is let go
                    else
                        scl_oe_o <= 1'b0;
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        mack_r <= ~sda_f;
                    else if (scl_fall)
                    begin
                        scl_oe_o <= mack_r;
                        state_r <= mack_r ? ST_RLOAD : ST_IDLE;
                    end
                end
            endcase
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge osc_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end
    end

    // ************************************************************
    // crossing: link domain to register port
    // ************************************************************
    logic wr_tgl_r;
    logic rd_tgl_r;
    logic soft_tgl_r;
    lcp_ptr_t xfer_ptr_r;
    logic [7:0] xfer_data_r;

    // ptr loads on the same edge as the write and read toggles, data with the write toggle only; both hold until the next event
    always_ff @(posedge osc_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_tgl_r <= 1'b0;
            rd_tgl_r <= 1'b0;
            soft_tgl_r <= 1'b0;
            xfer_ptr_r <= `LCP_PTR_FIRST;
            xfer_data_r <= 8'h00;
        end
        else
        begin
            if (do_data)
            begin
                wr_tgl_r <= ~wr_tgl_r;
                xfer_ptr_r <= ptr;
                xfer_data_r <= sh_r;
            end
            else if (enter_rload)
            begin
                rd_tgl_r <= ~rd_tgl_r;
                xfer_ptr_r <= ptr;
            end
            if ((state_r == ST_ADDR) && byte_in && !hit_call && hit_soft)
                soft_tgl_r <= ~soft_tgl_r;
        end
    end

    // ************************************************************
    // register port domain
    // ************************************************************
    logic [2:0] evt_f;
    logic [2:0] evt_q_r;
    logic [2:0] evt_edge;
    logic rd_ack_tgl_r;

    lcp_sync #(.W(3), .RST(3'h0)) u_evt_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({wr_tgl_r, rd_tgl_r, soft_tgl_r}),
        .q_o(evt_f)
    );

    lcp_sync #(.W(1), .RST(1'b0)) u_ack_sync
    (
        .clk_i(osc_clk_i),
        .rst_i(rst_i),
        .d_i(rd_ack_tgl_r),
        .q_o(rd_ack_f)
    );

    assign evt_edge = evt_f ^ evt_q_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            evt_q_r <= 3'h0;
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b0;
            soft_reset_call_o <= 1'b0;
            reg_addr_o <= `LCP_PTR_FIRST;
            reg_wdata_o <= 8'h00;
        end
        else
        begin
            evt_q_r <= evt_f;
            reg_wr_o <= evt_edge[2];
            reg_rd_o <= evt_edge[1];
            soft_reset_call_o <= evt_edge[0];
            if (evt_edge[2] || evt_edge[1])
                reg_addr_o <= xfer_ptr_r;
            if (evt_edge[2])
                reg_wdata_o <= xfer_data_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_data_x_r <= 8'h00;
            rd_ack_tgl_r <= 1'b0;
        end
        else if (reg_rd_o)
        begin
            rd_data_x_r <= reg_rdata_i;
            rd_ack_tgl_r <= ~rd_ack_tgl_r;
        end
    end
endmodule : lcp_target

// File: include/lcp_defines.svh
/*
 * Constants of the LED-driver serial target front end: pointer values,
 * reset values, call byte, control-register field positions.
 * Assumes inclusion by bare name from files under src/ and include/.
 */
`ifndef LCP_DEFINES_SVH
`define LCP_DEFINES_SVH


`define LCP_CTRL_RST 8'h80
`define LCP_GRP_ADDR_RST 8'hE0
`define LCP_SUB1_ADDR_RST 8'hE2
`define LCP_SUB2_ADDR_RST 8'hE4
`define LCP_SUB3_ADDR_RST 8'hE8
`define LCP_SOFT_RESET_CALL 8'h06
`define LCP_CTRL_EN_BIT 7
`define LCP_CTRL_OPT_MSB 7
`define LCP_CTRL_OPT_LSB 5
`define LCP_CTRL_PTR_MSB 4
`define LCP_PTR_FIRST 5'h00
`define LCP_PTR_LAST 5'h1B
`define LCP_PTR_PWM_FIRST 5'h02
`define LCP_PTR_PWM_LAST 5'h11
`define LCP_PTR_GRP_FIRST 5'h12
`define LCP_PTR_GRP_LAST 5'h13
`define LCP_PTR_SUB1 5'h18
`define LCP_PTR_SUB2 5'h19
`define LCP_PTR_SUB3 5'h1A
`define LCP_PTR_GRP_ADDR 5'h1B
`define LCP_OPT_ALL 2'b00
`define LCP_OPT_PWM 2'b01
`define LCP_OPT_GRP 2'b10
`define LCP_OPT_PWM_GRP 2'b11
`define LCP_BITS_PER_BYTE 4'h8
`define LCP_LAST_BIT 4'h7

`endif

// File: include/lcp_pkg.sv
/*
 * Types shared by the serial target front end.
 * Assumes lcp_defines.svh is compiled alongside.
 */
package lcp_pkg;

    typedef logic [4:0] lcp_ptr_t;

    typedef enum logic [7:0]
    {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_WBYTE    = 8'h08,
        ST_WACK     = 8'h10,
        ST_RLOAD    = 8'h20,
        ST_RBYTE    = 8'h40,
        ST_RACK     = 8'h80
    } lcp_state_t;

endpackage : lcp_pkg

// File: include/lcp_step_if.sv
/*
 * Carrier between the target engine and its pointer stepper.
 * Assumes both ends sit in the link clock domain.
 */
`timescale 1ns/10ps

interface lcp_step_if;
    logic [7:0] ctrl;
    logic [4:0] ptr_nxt;
    modport user (output ctrl, input ptr_nxt);
    modport stepper (input ctrl, output ptr_nxt);
endinterface : lcp_step_if

// File: src/lcp_sync.sv
/*
 * Three-stage synchroniser with agreement filter, per bit.
 * Assumes d_i is asynchronous to clk_i; q_o follows once stages 2 and 3 agree.
 */
`timescale 1ns/10ps

module lcp_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q_o <= RST;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a bit moves only when the last two stages agree
            q_o <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_o);
        end
    end
endmodule : lcp_sync

// File: src/lcp_ptr_step.sv
/*
 * Next register pointer from the control register's option code.
 * Assumes ctrl holds the current pointer and option bits.
 */
`timescale 1ns/10ps
`include "lcp_defines.svh"

module lcp_ptr_step
    import lcp_pkg::*;
(
    lcp_step_if.stepper step
);
    lcp_ptr_t ptr;
    lcp_ptr_t lo;
    lcp_ptr_t hi;

    always_comb
    begin
        ptr = step.ctrl[`LCP_CTRL_PTR_MSB:0];
        lo = `LCP_PTR_FIRST;
        hi = `LCP_PTR_LAST;
        unique case (step.ctrl[`LCP_CTRL_OPT_MSB-1:`LCP_CTRL_OPT_LSB])
            `LCP_OPT_ALL:
            begin
                lo = `LCP_PTR_FIRST;
                hi = `LCP_PTR_LAST;
            end
            `LCP_OPT_PWM:
            begin
                lo = `LCP_PTR_PWM_FIRST;
                hi = `LCP_PTR_PWM_LAST;
            end
            `LCP_OPT_GRP:
            begin
                lo = `LCP_PTR_GRP_FIRST;
                hi = `LCP_PTR_GRP_LAST;
            end
            `LCP_OPT_PWM_GRP:
            begin
                lo = `LCP_PTR_PWM_FIRST;
                hi = `LCP_PTR_GRP_LAST;
            end
        endcase
        if (!step.ctrl[`LCP_CTRL_EN_BIT])
            step.ptr_nxt = ptr;
        else if (ptr == hi)
            step.ptr_nxt = lo;
        else if (ptr >= `LCP_PTR_LAST)
            step.ptr_nxt = `LCP_PTR_FIRST;
        else
            step.ptr_nxt = ptr + 5'h01;
    end
endmodule : lcp_ptr_step

// File: tb/lcp_i2c_ctl.sv
/*
 * Behavioural bus controller that drives the serial target's pins.
 * Assumes the bench resolves both lines as open drain with pull-ups.
 */
`timescale 1ns/10ps

module lcp_i2c_ctl
#(
    parameter int Q = 480
)
(
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    // ********************************
    // bit and byte cycles
    // ********************************
    initial
    begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // target may stretch the clock; bounded so a stuck line cannot hang us
    task automatic rise;
        scl_low_o = 1'b0;
        for (int i = 0; i < 3000 && !scl_i; i++) #10;
        if (!scl_i)
        begin
            $display("[ERR] scl release exp 1 got 0");
            tb_top.err_count++;
        end
    endtask : rise

    task automatic start;
        #Q;
        sda_low_o = 1'b0;
        #Q;
        rise();
        #Q;
        sda_low_o = 1'b1;
        #Q;
        scl_low_o = 1'b1;
    endtask : start

    task automatic stop;
        #Q;
        sda_low_o = 1'b1;
        #Q;
        rise();
        #Q;
        sda_low_o = 1'b0;
        #Q;
    endtask : stop

    task automatic bit_io(input logic b, output logic r);
        #Q;
        sda_low_o = !b;
        #Q;
        rise();
        #Q;
        r = sda_i;
        #Q;
        scl_low_o = 1'b1;
    endtask : bit_io

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte

    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(!more, r);
    endtask : rd_byte
endmodule : lcp_i2c_ctl

// File: tb/lcp_target_asserts.sv
/*
 * Checker of the serial target's pin and register-port outputs.
 * Assumes it is bound onto lcp_target and sampled on clk_i.
 */
`timescale 1ns/10ps

module lcp_target_asserts
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic [4:0] reg_addr_o,
    input wire logic [7:0] reg_wdata_o,
    input wire logic reg_wr_o,
    input wire logic reg_rd_o,
    input wire logic soft_reset_call_o
);
    // ********************************
    // helpers and properties
    // ********************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic sda_d_r;
    logic in_soft_r;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) sda_d_r <= 1'b1; else sda_d_r <= sda_i;
    // soft call open until the bus sees a stop
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) in_soft_r <= 1'b0;
        else if (soft_reset_call_o) in_soft_r <= 1'b1;
        else if (scl_i && sda_i && !sda_d_r) in_soft_r <= 1'b0;

    property p_wr_pulse; reg_wr_o |=> !reg_wr_o [*8]; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe bad");
    property p_rd_pulse; reg_rd_o |=> !reg_rd_o [*8]; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe bad");
    property p_soft; soft_reset_call_o |=> !soft_reset_call_o ##1 !soft_reset_call_o; endproperty
    a_soft: assert property (p_soft) else $error("soft call pulse bad");
    property p_wr_range; reg_wr_o |-> reg_addr_o <= 5'h1B; endproperty
    a_wr_range: assert property (p_wr_range) else $error("reserved write");
    property p_wdata; $changed(reg_wdata_o) |-> reg_wr_o; endproperty
    a_wdata: assert property (p_wdata) else $error("write data moved");
    property p_fetch; reg_rd_o |-> scl_oe_o ##1 scl_oe_o; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch without stretch");
    property p_soft_nowr; in_soft_r |-> !reg_wr_o; endproperty
    a_soft_nowr: assert property (p_soft_nowr) else $error("write in soft call");
    property p_quiet; $fell(rst_i) |-> (!sda_oe_o && !scl_oe_o) [*4]; endproperty
    a_quiet: assert property (p_quiet) else $error("pins driven after reset");
    c_wr: cover property (reg_wr_o);
    c_rd: cover property (reg_rd_o);
    c_soft: cover property (soft_reset_call_o);
endmodule : lcp_target_asserts

bind lcp_target lcp_target_asserts u_lcp_target_asserts (.clk_i, .rst_i, .scl_i, .sda_i,
    .scl_oe_o, .sda_oe_o, .reg_addr_o, .reg_wdata_o, .reg_wr_o, .reg_rd_o, .soft_reset_call_o);

// File: tb/tb_top.sv
/*
 * Top bench: serial target, bus controller model, register-side model.
 * Assumes clk_i at 100 MHz and a free-running 160 ns oscillator.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %0h got %0h", n, e, g); err_count++; end end

module tb_top;
    // ********************************
    // design, model and scenarios
    // ********************************
    logic clk_i, rst_i, osc_clk_i, scl_i, sda_i, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic [6:0] target_addr_i;
    logic group_call_en_i;
    logic [2:0] sub_call_en_i;
    logic [4:0] reg_addr_o;
    logic [7:0] reg_wdata_o, reg_rdata_i;
    logic reg_wr_o, reg_rd_o, soft_reset_call_o, scl_low, sda_low;
    int err_count = 0;
    int num_checks = 0;
    int srst_seen = 0;
    logic [12:0] wq[$];
    assign scl_i = !(scl_low || scl_oe_o);
    assign sda_i = !(sda_low || sda_oe_o);
    assign reg_rdata_i = 8'hA0 + {3'b000, reg_addr_o};
    lcp_target u_lcp_target (.clk_i, .rst_i, .osc_clk_i, .scl_i, .scl_o, .scl_oe_o, .sda_i,
        .sda_o, .sda_oe_o, .target_addr_i, .group_call_en_i, .sub_call_en_i, .reg_addr_o,
        .reg_wdata_o, .reg_wr_o, .reg_rd_o, .reg_rdata_i, .soft_reset_call_o);
    lcp_i2c_ctl u_lcp_i2c_ctl (.scl_i, .sda_i, .scl_low_o(scl_low), .sda_low_o(sda_low));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        osc_clk_i = 1'b0;
        #37;
        forever #80 osc_clk_i = ~osc_clk_i;
    end
    always @(posedge clk_i)
    begin
        if (reg_wr_o) wq.push_back({reg_addr_o, reg_wdata_o});
        if (soft_reset_call_o) srst_seen++;
    end

    task automatic probe(input logic [7:0] a, input logic exp);
        logic ack;
        u_lcp_i2c_ctl.start();
        u_lcp_i2c_ctl.wr_byte(a, ack);
        u_lcp_i2c_ctl.stop();
        `CHK($sformatf("ack %h", a), exp, ack)
    endtask : probe

    task automatic set_en(input logic g, input logic [2:0] s);
        @(posedge clk_i);
        #1;
        group_call_en_i = g;
        sub_call_en_i = s;
        repeat (40) @(posedge clk_i);
    endtask : set_en

    task automatic t_calls;
        probe({target_addr_i, 1'b0}, 1'b1);
        probe(8'hE0, 1'b1);
        probe(8'hE2, 1'b0);
        probe(8'hE4, 1'b0);
        probe(8'hE8, 1'b0);
        probe(8'h07, 1'b0);
        set_en(1'b0, 3'b010);
        probe(8'hE4, 1'b1);
        probe(8'hE0, 1'b0);
        set_en(1'b1, 3'b000);
        $display("t_calls done");
    endtask : t_calls

    // group call row first: later rows overwrite the group address
    task automatic t_step;
        logic [7:0] ctl [6] = '{8'hD3, 8'hB1, 8'hF3, 8'h05, 8'h9B, 8'hFB};
        logic [4:0] nx [6] = '{5'h12, 5'h02, 5'h02, 5'h05, 5'h00, 5'h00};
        logic ack;
        for (int i = 0; i < 6; i++)
        begin
            wq.delete();
            u_lcp_i2c_ctl.start();
            u_lcp_i2c_ctl.wr_byte((i == 0) ? 8'hE0 : {target_addr_i, 1'b0}, ack);
            u_lcp_i2c_ctl.wr_byte(ctl[i], ack);
            u_lcp_i2c_ctl.wr_byte({4'h3, 4'(i)}, ack);
            u_lcp_i2c_ctl.wr_byte({4'h5, 4'(i)}, ack);
            u_lcp_i2c_ctl.stop();
            `CHK("wr count", 2, wq.size())
            `CHK("wr first", {ctl[i][4:0], 4'h3, 4'(i)}, wq[0])
            `CHK("wr next", {nx[i], 4'h5, 4'(i)}, wq[1])
        end
        probe(8'h34, 1'b1);
        probe(8'hE0, 1'b0);
        $display("t_step done");
    endtask : t_step

    task automatic t_read;
        logic ack;
        logic [7:0] d;
        u_lcp_i2c_ctl.start();
        u_lcp_i2c_ctl.wr_byte({target_addr_i, 1'b0}, ack);
        u_lcp_i2c_ctl.wr_byte(8'h1C, ack);
        u_lcp_i2c_ctl.stop();
        `CHK("reserved ack", 1'b0, ack)
        u_lcp_i2c_ctl.start();
        u_lcp_i2c_ctl.wr_byte({target_addr_i, 1'b0}, ack);
        u_lcp_i2c_ctl.wr_byte(8'h94, ack);
        u_lcp_i2c_ctl.start();
        u_lcp_i2c_ctl.wr_byte({target_addr_i, 1'b1}, ack);
        `CHK("read ack", 1'b1, ack)
        u_lcp_i2c_ctl.rd_byte(1'b1, d);
        `CHK("read first", 8'hB4, d)
        `CHK("pin out", 2'b00, {scl_o, sda_o})
        u_lcp_i2c_ctl.rd_byte(1'b0, d);
        `CHK("read next", 8'hB5, d)
        u_lcp_i2c_ctl.stop();
        $display("t_read done");
    endtask : t_read

    task automatic t_soft;
        logic ack;
        logic [7:0] d;
        wq.delete();
        srst_seen = 0;
        u_lcp_i2c_ctl.start();
        u_lcp_i2c_ctl.wr_byte(8'h06, ack);
        `CHK("soft ack", 1'b1, ack)
        u_lcp_i2c_ctl.wr_byte(8'h9A, ack);
        u_lcp_i2c_ctl.stop();
        `CHK("soft pulse", 1, srst_seen)
        `CHK("soft writes", 0, wq.size())
        u_lcp_i2c_ctl.start();
        u_lcp_i2c_ctl.wr_byte({target_addr_i, 1'b1}, ack);
        u_lcp_i2c_ctl.rd_byte(1'b0, d);
        u_lcp_i2c_ctl.stop();
        `CHK("ctrl kept", 8'hB6, d)
        $display("t_soft done");
    endtask : t_soft

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    initial
    begin
        rst_i = 1'b1;
        target_addr_i = 7'h7C;
        group_call_en_i = 1'b1;
        sub_call_en_i = 3'b000;
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        repeat (4) @(posedge osc_clk_i);
        t_calls();
        t_step();
        t_read();
        t_soft();
        print_verdict();
    end
    initial
    begin
        #950_000;
        err_count++;
        print_verdict();
    end
endmodule : tb_top
